//--- design/dpoa_divider_align.sv
// Two channels of cascaded dividers with coarse phase offset and output alignment.
// Assumes all inputs synchronous to sys_clk except alignPin_n, which is resynchronised.
// Exclusion and calibration arrive as plain level inputs.
// Function
// R1: Phase code is start-high bit times 16 plus four phase offset bits.
// R2: Code up to 15 delays the stage by code input-clock periods.
// R3: Code 16 or more delays by code minus 16 plus low count plus one.
// R4: Channel delay is first-stage plus second-stage delay, each in own input periods.
// R5: Alignment holds non-excluded outputs static, then releases them together.
// R6: A low pulse on the alignment pin triggers an alignment on release.
// R7: Setting then clearing soft align, soft reset or distribution power-down aligns.
// R8: Releasing the reset pin or the sleep pin triggers an alignment.
// R9: An alignment is performed as part of power-up.
// R10: Oscillator calibration holds an alignment request until it completes.
// R11: Pin response may vary by one divider input cycle.
// R12: Clocking resumes about fourteen to fifteen cycles after pin rise, plus one.
// R13: Soft align changes take effect only on an update-registers write.
// R14: Static level and starting phase come from start-high bit and phase offset.
// R15: Both outputs of a pair follow their shared channel divider.
// R16: Excluded channels keep clocking through any alignment.
// R17: Software sets soft reset and mirror bit, then clears both.
// R18: The alignment pin passes through a two-flop synchroniser first.
`timescale 1ns/100ps

module dpoa_divider_align
    import dpoa_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic alignPin_n,
    input wire logic sleep_pin_n,
    input wire logic calBusy,
    input wire logic [NUM_CH-1:0] alignExclude,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [9:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic regRdValid,
    output logic [2*NUM_CH-1:0] pairOut,
    output logic alignActive
);

    // Two cascaded stages per channel, first stage at even index
    localparam int NUM_STAGES = 2 * NUM_CH;

    typedef struct packed {
        // Register copies; shadow until an update write, except port config which is live at once
        logic [7:0] portCfg;
        logic [NUM_DIV_REGS-1:0][7:0] shadowRegs;
        logic [NUM_DIV_REGS-1:0][7:0] liveRegs;
        logic [7:0] alignShadow;
        logic [7:0] alignLive;

        // Pin synchroniser, metastable flop first
        logic pinMeta;
        logic pinSafe;

        // Alignment hold and release timing
        logic alignActive;
        logic [3:0] releaseCnt;

        // Per-stage divider state
        logic [NUM_STAGES-1:0] stageLvl;
        logic [NUM_STAGES-1:0] stageRun;
        logic [NUM_STAGES-1:0][4:0] stageWait;
        logic [NUM_STAGES-1:0][3:0] stageCnt;

        // Registered read answer
        logic [7:0] rdData;
        logic rdValid;
    } dpoa_state_type;

    dpoa_state_type state_r;
    dpoa_state_type state_nxt;

    // Divider table lookup, used by both the write and the read path
    function automatic logic [3:0] div_reg_index(input logic [9:0] addr);
        // Bit 3 marks a hit, bits 2:0 index the table
        case (addr)
            ADDR_CH3_S1_COUNTS: begin
                return 4'h8;
            end
            ADDR_CH3_PHASE: begin
                return 4'h9;
            end
            ADDR_CH3_S2_COUNTS: begin
                return 4'ha;
            end
            ADDR_CH3_START_HIGH: begin
                return 4'hb;
            end
            ADDR_CH4_S1_COUNTS: begin
                return 4'hc;
            end
            ADDR_CH4_PHASE: begin
                return 4'hd;
            end
            ADDR_CH4_S2_COUNTS: begin
                return 4'he;
            end
            ADDR_CH4_START_HIGH: begin
                return 4'hf;
            end
            default: begin
                return 4'h0;
            end
        endcase
    endfunction

    // Stage delay in input periods from its phase code
    function automatic logic [4:0] stage_delay(
        input logic startHigh,
        input logic [3:0] phaseCount,
        input logic [3:0] lowCount
    );
        logic [4:0] code;
        code = {startHigh, phaseCount}; // R1
        if (code <= 5'h0f) begin
            // Small codes wait whole input periods only
            return code; // R2
        end else begin
            // Code minus 16 is just the offset field once the 16 weight is set
            return 5'({1'b0, phaseCount} + {1'b0, lowCount} + 5'h01); // R3
        end
    endfunction

    logic softReset;
    logic alignReq;
    logic pinReq;
    logic softAlignReq;
    logic distReq;
    logic sleepReq;
    logic [3:0] wrHit;
    logic [3:0] rdHit;

    assign softReset = state_r.portCfg[SOFT_RESET_BIT] & state_r.portCfg[SOFT_RESET_MIRROR_BIT];
    assign wrHit = div_reg_index(regAddr);
    assign rdHit = div_reg_index(regAddr);

    // Each request source on its own, all active high
    assign pinReq = ~state_r.pinSafe; // R6 R18
    assign softAlignReq = state_r.alignLive[SOFT_ALIGN_BIT]; // R7 R13
    assign distReq = state_r.alignLive[DIST_PWRDN_BIT]; // R7
    assign sleepReq = ~sleep_pin_n; // R8

    // Every source holds the request; release starts only when all are gone
    assign alignReq = pinReq | softAlignReq | distReq
        | softReset // R7 R17
        | sleepReq
        | calBusy; // R10

    // Next-state logic for registers, alignment control and dividers
    always_comb begin
        // Loop scratch, cleared first so nothing is latched
        int ch;
        int st;
        int base;
        logic en;
        logic [3:0] lowCnt;
        logic [3:0] highCnt;
        logic [3:0] phaseCount;
        logic startHigh;

        ch = 0;
        st = 0;
        base = 0;
        en = 1'b0;
        lowCnt = 4'h0;
        highCnt = 4'h0;
        phaseCount = 4'h0;
        startHigh = 1'b0;
        state_nxt = state_r;
        state_nxt.rdValid = regRdEn;

        // Register writes; soft reset is live at once, no update needed
        if (regWrEn) begin
            case (regAddr)
                ADDR_PORT_CFG: begin
                    // Soft reset and mirror bits live here
                    state_nxt.portCfg = regWrData; // R17
                end
                ADDR_ALIGN_DIST: begin
                    state_nxt.alignShadow = regWrData;
                end
                ADDR_UPDATE: begin
                    // Shadow copies go live together, never one by one
                    if (regWrData[UPDATE_BIT]) begin
                        state_nxt.liveRegs = state_r.shadowRegs;
                        state_nxt.alignLive = state_r.alignShadow; // R13
                    end
                end
                default: begin
                    // Unmapped addresses fall through and are ignored
                    if (wrHit[3]) begin
                        state_nxt.shadowRegs[wrHit[2:0]] = regWrData;
                    end
                end
            endcase
        end

        // Soft reset restores defaults everywhere except its own register
        if (softReset) begin
            state_nxt.shadowRegs = '0;
            state_nxt.liveRegs = '0;
            state_nxt.alignShadow = REG_RESET;
            state_nxt.alignLive = REG_RESET;
        end

        // Reads return shadow contents one cycle later; update reads as zero
        if (regRdEn) begin
            case (regAddr)
                ADDR_PORT_CFG: begin
                    state_nxt.rdData = state_r.portCfg;
                end
                ADDR_ALIGN_DIST: begin
                    state_nxt.rdData = state_r.alignShadow;
                end
                default: begin
                    // Divider table, else unmapped reads zero
                    if (rdHit[3]) begin
                        state_nxt.rdData = state_r.shadowRegs[rdHit[2:0]];
                    end else begin
                        state_nxt.rdData = 8'h00;
                    end
                end
            endcase
        end

        // Two-flop synchroniser on the pin, first flop feeds only the second
        state_nxt.pinMeta = alignPin_n; // R18
        state_nxt.pinSafe = state_r.pinMeta; // R11 R18

        // Release counter: held while requested, fixed latency after
        // A request during release reloads the count from the top
        if (alignReq) begin
            state_nxt.alignActive = 1'b1; // R5
            state_nxt.releaseCnt = RELEASE_CYCLES; // R12
        end else if (state_r.alignActive) begin
            if (state_r.releaseCnt == 4'h0) begin
                state_nxt.alignActive = 1'b0; // R5 R12
            end else begin
                state_nxt.releaseCnt = 4'(state_r.releaseCnt - 4'h1);
            end
        end

        // Stage loop; stage 1 of a channel precedes stage 2 so its edge is seen
        for (int s = 0; s < NUM_STAGES; s++) begin
            ch = s / 2;
            st = s % 2;
            base = ch * REGS_PER_CH;

            // Fetch this stage's counts and phase field from the live copies
            if (st == 0) begin
                lowCnt = state_r.liveRegs[base + IDX_S1_COUNTS][LOW_COUNT_LSB +: 4];
                highCnt = state_r.liveRegs[base + IDX_S1_COUNTS][HIGH_COUNT_LSB +: 4];
                phaseCount = state_r.liveRegs[base + IDX_PHASE][3:0];
                en = 1'b1;
            end else begin
                lowCnt = state_r.liveRegs[base + IDX_S2_COUNTS][LOW_COUNT_LSB +: 4];
                highCnt = state_r.liveRegs[base + IDX_S2_COUNTS][HIGH_COUNT_LSB +: 4];
                phaseCount = state_r.liveRegs[base + IDX_PHASE][STAGE2_PHASE_LSB +: 4];
                // Second stage clocks on the first stage's rising output
                en = state_nxt.stageLvl[s - st] & ~state_r.stageLvl[s - st]; // R4
                // A first stage preset high starts running without a visible rise,
                // so its start counts as the edge; otherwise a start-high delay
                // would lose one whole first-stage period
                en = en | (state_nxt.stageRun[s - st] & ~state_r.stageRun[s - st]); // R3 R4
            end
            // Start-high bit per stage: bit 0 first stage, bit 1 second
            startHigh = state_r.liveRegs[base + IDX_START_HIGH][st];

            if (state_r.alignActive && !alignExclude[ch]) begin // R16
                // Static preset level and the delay to apply at release
                state_nxt.stageLvl[s] = startHigh; // R14
                state_nxt.stageRun[s] = 1'b0; // R5
                state_nxt.stageWait[s] = stage_delay(startHigh, phaseCount, lowCnt); // R14
                state_nxt.stageCnt[s] = 4'h0;
            end else if (en) begin
                // Running stage: wait out its delay, then alternate high and low
                if (!state_r.stageRun[s]) begin
                    if (state_r.stageWait[s] == 5'h00) begin
                        state_nxt.stageRun[s] = 1'b1;
                        state_nxt.stageLvl[s] = 1'b1;
                        state_nxt.stageCnt[s] = highCnt;
                    end else begin
                        state_nxt.stageWait[s] = 5'(state_r.stageWait[s] - 5'h01); // R2 R3
                    end
                end else if (state_r.stageCnt[s] == 4'h0) begin
                    // High lasts high count plus one, low lasts low count plus one
                    state_nxt.stageLvl[s] = ~state_r.stageLvl[s];
                    state_nxt.stageCnt[s] = state_r.stageLvl[s] ? lowCnt : highCnt;
                end else begin
                    state_nxt.stageCnt[s] = 4'(state_r.stageCnt[s] - 4'h1);
                end
            end
        end
    end

    // State register; reset leaves alignment active so power-up aligns
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // Registers back to their defaults
            state_r.portCfg <= REG_RESET;
            state_r.shadowRegs <= '0;
            state_r.liveRegs <= '0;
            state_r.alignShadow <= REG_RESET;
            state_r.alignLive <= REG_RESET;
            // Synchroniser reads low so the pin request outlasts reset by two cycles
            state_r.pinMeta <= 1'b0;
            state_r.pinSafe <= 1'b0;
            // Alignment already held, so leaving reset releases like a pin edge
            state_r.alignActive <= 1'b1; // R8 R9
            state_r.releaseCnt <= RELEASE_CYCLES;
            // Dividers stopped at a low level; excluded channels start at the first edge, others at the first release
            state_r.stageLvl <= '0;
            state_r.stageRun <= '0;
            state_r.stageWait <= '0;
            state_r.stageCnt <= '0;
            // No read answer pending
            state_r.rdData <= 8'h00;
            state_r.rdValid <= 1'b0;
        end else begin
            // Every field moves on every edge, no enable
            state_r <= state_nxt;
        end
    end

    // Both outputs of a pair come from the second stage of their channel
    // Stage 1 feeds only stage 2, never a pin
    for (genvar c = 0; c < NUM_CH; c++) begin : g_pair
        assign pairOut[2*c] = state_r.stageLvl[2*c+1]; // R15
        assign pairOut[2*c+1] = state_r.stageLvl[2*c+1]; // R15
    end

    // Read answer straight from its flops
    assign regRdData = state_r.rdData;
    assign regRdValid = state_r.rdValid;

    // Hold flag shown outside, registered so it never glitches
    assign alignActive = state_r.alignActive;

endmodule // dpoa_divider_align

//--- design/dpoa_pkg.sv
// Package for the cascaded channel divider phase offset and output alignment block.
// Assumes one system clock that also serves as the channel divider input clock.
package dpoa_pkg;

    // Register addresses on the internal register port
    localparam logic [9:0] ADDR_PORT_CFG = 10'h000;
    localparam logic [9:0] ADDR_CH3_S1_COUNTS = 10'h199;
    localparam logic [9:0] ADDR_CH3_PHASE = 10'h19a;
    localparam logic [9:0] ADDR_CH3_S2_COUNTS = 10'h19b;
    localparam logic [9:0] ADDR_CH3_START_HIGH = 10'h19c;
    localparam logic [9:0] ADDR_CH4_S1_COUNTS = 10'h19e;
    localparam logic [9:0] ADDR_CH4_PHASE = 10'h19f;
    localparam logic [9:0] ADDR_CH4_S2_COUNTS = 10'h1a0;
    localparam logic [9:0] ADDR_CH4_START_HIGH = 10'h1a1;
    localparam logic [9:0] ADDR_ALIGN_DIST = 10'h230;
    localparam logic [9:0] ADDR_UPDATE = 10'h232;

    // Divider register table: four per channel, counts1, phase, counts2, start high
    localparam int NUM_DIV_REGS = 8;
    localparam int REGS_PER_CH = 4;
    localparam int IDX_S1_COUNTS = 0;
    localparam int IDX_PHASE = 1;
    localparam int IDX_S2_COUNTS = 2;
    localparam int IDX_START_HIGH = 3;

    // Field positions
    localparam int SOFT_RESET_BIT = 5;
    localparam int SOFT_RESET_MIRROR_BIT = 2;
    localparam int SOFT_ALIGN_BIT = 0;
    localparam int DIST_PWRDN_BIT = 1;
    localparam int UPDATE_BIT = 0;
    localparam int LOW_COUNT_LSB = 4;
    localparam int HIGH_COUNT_LSB = 0;
    localparam int STAGE2_PHASE_LSB = 4;

    // Values after reset
    localparam logic [7:0] REG_RESET = 8'h00;

    // Release latency from the alignment pin rising edge, in divider input cycles
    localparam int SYNC_STAGES = 2;
    localparam int ALIGN_LATENCY_CYC = 14;
    localparam logic [3:0] RELEASE_CYCLES = 4'(ALIGN_LATENCY_CYC - SYNC_STAGES - 1);

endpackage

//--- test/dpoa_divider_align_properties.sv
// Port assertions for the divider alignment block.
// Assumes one sys_clk domain; bound onto every instance of the block.
`timescale 1ns/100ps
module dpoa_divider_align_properties
    import dpoa_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic alignPin_n,
    input wire logic sleep_pin_n,
    input wire logic calBusy,
    input wire logic [NUM_CH-1:0] alignExclude,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [9:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic [2*NUM_CH-1:0] pairOut,
    input wire logic alignActive
);
    default clocking cbk @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    // Pin released with the sleep pin high and calibration idle
    sequence pinPulse;
        !alignPin_n ##1 alignPin_n && sleep_pin_n && !calBusy;
    endsequence
    sequence heldEight;
        alignActive [*8];
    endsequence
    // Register port and request sources
    chk_read_answer: assert property (regRdEn |=> regRdValid) else $error("no rd valid");
    chk_read_quiet: assert property (!regRdEn |=> !regRdValid) else $error("stray rd valid");
    chk_pin_request: assert property (!alignPin_n [*3] |=> alignActive) else $error("pin");
    chk_sleep_request: assert property (!sleep_pin_n |=> alignActive) else $error("sleep");
    chk_cal_request: assert property (calBusy |=> alignActive) else $error("cal");
    // Hold length and release moment; held level may settle one cycle late
    chk_hold_min: assert property ($rose(alignActive) |-> heldEight) else $error("short");
    chk_release_time: assert property (pinPulse |-> heldEight ##[6:8] !alignActive)
        else $error("release time");
    chk_pair_equal: assert property (pairOut[1] == pairOut[0] && pairOut[3] == pairOut[2])
        else $error("pair differs");
    chk_static_hold: assert property (alignActive && $past(alignActive) &&
        $past(alignActive, 2) && !alignExclude[0] |-> $stable(pairOut[1:0])) else $error("moved");
endmodule // dpoa_divider_align_properties

bind dpoa_divider_align dpoa_divider_align_properties #(.NUM_CH(NUM_CH))
    dpoa_divider_align_properties_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .alignPin_n(alignPin_n), .sleep_pin_n(sleep_pin_n), .calBusy(calBusy),
    .alignExclude(alignExclude), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .pairOut(pairOut), .alignActive(alignActive));

//--- test/dpoa_pin_driver.sv
// Controller model driving the active-low alignment pin.
// Assumes pulseReq is driven non-blocking at the falling edge.
`timescale 1ns/100ps
module dpoa_pin_driver (
    input wire logic sys_clk,
    input wire logic pulseReq,
    output logic alignPin_n = 1'b1
);
    int lowLeft = 0;
    // Idles high like a pull-up; low time outlasts the synchroniser
    always @(negedge sys_clk) begin
        if (pulseReq) lowLeft = 5;
        alignPin_n <= (lowLeft == 0);
        if (lowLeft > 0) lowLeft = lowLeft - 1;
    end
endmodule // dpoa_pin_driver

//--- test/tb_dpoa_divider_align.sv
// Self-checking bench for the divider alignment block.
// Assumes the pin driver model and the bound property checker.
`timescale 1ns/100ps
module tb_dpoa_divider_align
    import dpoa_pkg::*;
;
    logic sys_clk = 1'b0, reset_n = 1'b0, sleep_pin_n = 1'b1, calBusy = 1'b0, pulseReq = 1'b0;
    logic regWrEn = 1'b0, regRdEn = 1'b0, regRdValid, alignActive, alignPin_n;
    logic [1:0] alignExclude = 2'h2;
    logic [3:0] pairOut;
    logic [7:0] regWrData = 8'h00, regRdData, expQ[$];
    logic [9:0] regAddr = 10'h000;
    logic [15:0] lfsr = 16'hc718;
    logic [9:0] regList[11] = '{ADDR_PORT_CFG, ADDR_CH3_S1_COUNTS, ADDR_CH3_PHASE,
        ADDR_CH3_S2_COUNTS, ADDR_CH3_START_HIGH, ADDR_CH4_S1_COUNTS, ADDR_CH4_PHASE,
        ADDR_CH4_S2_COUNTS, ADDR_CH4_START_HIGH, ADDR_ALIGN_DIST, ADDR_UPDATE};
    int bad_count = 0, total_checks = 0;
    dpoa_divider_align #(.NUM_CH(2)) dpoa_divider_align_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .alignPin_n(alignPin_n), .sleep_pin_n(sleep_pin_n), .calBusy(calBusy),
        .alignExclude(alignExclude), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .pairOut(pairOut), .alignActive(alignActive));
    dpoa_pin_driver dpoa_pin_driver_i (.sys_clk(sys_clk), .pulseReq(pulseReq),
        .alignPin_n(alignPin_n));
    // 100 MHz clock
    initial forever #5 sys_clk = ~sys_clk;
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task complete_run();
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Inputs move on the falling edge so the design samples settled values
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {regWrEn, regAddr, regWrData} <= {1'b1, a, d};
        @(negedge sys_clk);
        regWrEn <= 1'b0;
    endtask
    task rd(input logic [9:0] a, input logic [7:0] e);
        expQ.push_back(e);
        @(negedge sys_clk);
        {regRdEn, regAddr} <= {1'b1, a};
        @(negedge sys_clk);
        regRdEn <= 1'b0;
    endtask
    // Bounded wait for release; a hang ends the run
    task waitIdle(input int lo, input int hi, input string what);
        int n;
        n = 0;
        while (alignActive !== 1'b0) begin
            @(negedge sys_clk);
            n++;
            if (n > 300) begin
                check(what, 16'h0, 16'h1);
                complete_run();
            end
        end
        check(what, 16'(n >= lo && n <= hi), 16'h1);
    endtask
    // Read answers meet the oldest noted expectation
    always @(negedge sys_clk) begin
        if (regRdValid === 1'b1) check("rd data", 16'(regRdData), 16'(expQ.pop_front()));
    end
    initial begin
        #900us;
        check("watchdog", 16'h0, 16'h1);
        complete_run();
    end
    initial begin
        int t3, t4, d;
        logic [7:0] m, p1, p2, sh, a;
        repeat (16) @(negedge sys_clk);
        reset_n <= 1'b1;
        waitIdle(12, 16, "power-up align");
        foreach (regList[j]) rd(regList[j], REG_RESET);
        rd(10'h3ff, 8'h00);
        // Soft align, distribution power-down, soft reset with mirror
        for (int i = 0; i < 3; i++) begin
            wr(i < 2 ? ADDR_ALIGN_DIST : ADDR_PORT_CFG, i < 2 ? 8'(i + 1) : 8'h24);
            repeat (3) @(negedge sys_clk);
            check("before update", 16'(alignActive), 16'(i == 2));
            if (i < 2) wr(ADDR_UPDATE, 8'h01);
            repeat (2) @(negedge sys_clk);
            check("soft set", 16'(alignActive), 16'h1);
            wr(i < 2 ? ADDR_ALIGN_DIST : ADDR_PORT_CFG, 8'h00);
            if (i < 2) wr(ADDR_UPDATE, 8'h01);
            waitIdle(9, 14, "soft release");
        end
        // Pin, sleep pin and calibration, channel 4 excluded
        for (int i = 0; i < 3; i++) begin
            {pulseReq, sleep_pin_n, calBusy} <= {i == 0, i != 1, i == 2};
            repeat (4) @(negedge sys_clk);
            a = {7'h0, pairOut[2]};
            repeat (2) @(negedge sys_clk);
            check("request holds", 16'(alignActive), 16'h1);
            check("excluded runs", 16'(pairOut[2] ^ a[0]), 16'h1);
            {pulseReq, sleep_pin_n, calBusy} <= 3'b010;
            waitIdle(8, 20, "request release");
        end
        alignExclude <= 2'h0;
        // Random coarse offsets on channel 3 against a zero-offset channel 4
        for (int k = 0; k < 3; k++) begin
            {m, p1, p2, sh} = {rnd() & 8'h03, rnd() & 8'h0f, rnd() & 8'h03, rnd() & 8'h01};
            d = ((sh != 0) ? p1 + m + 1 : p1) + p2 * (m + 2);
            wr(ADDR_CH3_S1_COUNTS, m << LOW_COUNT_LSB);
            wr(ADDR_CH4_S1_COUNTS, m << LOW_COUNT_LSB);
            wr(ADDR_CH3_PHASE, (p2 << STAGE2_PHASE_LSB) | p1);
            wr(ADDR_CH3_START_HIGH, sh);
            wr(ADDR_UPDATE, 8'h01);
            rd(ADDR_CH3_PHASE, (p2 << STAGE2_PHASE_LSB) | p1);
            pulseReq <= 1'b1;
            @(negedge sys_clk);
            pulseReq <= 1'b0;
            repeat (6) @(negedge sys_clk);
            check("held low", 16'(pairOut), 16'h0);
            waitIdle(5, 16, "pin release");
            {t3, t4} = {-32'sd1, -32'sd1};
            for (int c = 0; c < 400 && (t3 < 0 || t4 < 0); c++) begin
                @(negedge sys_clk);
                if (t3 < 0 && pairOut[0] === 1'b1) t3 = c;
                if (t4 < 0 && pairOut[2] === 1'b1) t4 = c;
            end
            if (t3 < 0 || t4 < 0) begin
                check("edge seen", 16'h0, 16'h1);
                complete_run();
            end
            check("coarse delay", 16'(t3 - t4), 16'(d));
        end
        // Stage 2 start-high sets the held output level
        wr(ADDR_CH3_START_HIGH, 8'h02);
        wr(ADDR_UPDATE, 8'h01);
        sleep_pin_n <= 1'b0;
        repeat (4) @(negedge sys_clk);
        check("held levels", 16'(pairOut), 16'h3);
        complete_run();
    end
endmodule // tb_dpoa_divider_align
